// ==== verilog/thermocouple_input_config.sv ====
// Parameter bytes and result words of a two-channel thermocouple/millivolt input
//
// Behaviour
// - The diagnostic interrupt is enabled by byte value 40h and disabled by 00h.
// - Open-circuit byte bit 0 enables detection on channel 0, bit 1 on channel 1, bits 7-2 reserved.
// - Temperature unit bits 1:0 select Celsius 00, Fahrenheit 01, Kelvin 10; upper bits reserved.
// - Mains rejection bits 1:0 select 60 Hz with 01 and 50 Hz with 10; upper bits reserved.
// - Mains rejection resets to 02h; diagnostic, open-circuit and unit bytes reset to 00h.
// - Each channel range code resets to C1h, the internally compensated default.
// - A channel with range code FFh is deactivated and performs no measurement.
// - Range 11h maps +80 mV to 27648, 0 V to 0 and -80 mV to 9400h.
// - Range 11h has an overrange band up to 32511 and an underrange band down to 8100h.
// - Range 21h maps +80 mV to 16384, 0 V to 0 and -80 mV to C000h.
// - Range 21h has overrange up to 5000h and underrange down to B000h.
`timescale 1ns/1ps
module thermocouple_input_config #(
    parameter int NUM_CH = 2,
    parameter int RAW_W  = 24
) (
    input  wire logic                                      ref_clk,
    input  wire logic                                      resetn,
    input  wire logic                                      prmWrite,
    input  wire logic                                      prmRead,
    input  wire thermocouple_input_pkg::param_req_s        prmReq,
    input  wire logic                                      systemRunning,
    output logic                                           prmAccept,
    output logic                                           prmRefused,
    output logic      [7:0]                                prmRdData_r,
    output logic                                           prmRdValid_r,
    input  wire logic [NUM_CH-1:0]                         sampleValid,
    input  wire thermocouple_input_pkg::sample_s [NUM_CH-1:0] sample,
    output logic      [NUM_CH*16-1:0]                      inputData_r,
    output logic      [NUM_CH-1:0]                         resultUpdate_r,
    output logic      [NUM_CH-1:0]                         channelActive,
    output logic      [NUM_CH-1:0]                         openCircuitEnable,
    output logic                                           diagIrqEnable,
    output logic      [1:0]                                mainsRejection,
    output logic      [1:0]                                unitSel
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (NUM_CH != 2) begin : g_bad_ch
        $error("NUM_CH must be 2");
    end
    if (RAW_W < 17 || RAW_W > 24) begin : g_bad_raw
        $error("RAW_W must be 17 to 24");
    end

    localparam int PN = thermocouple_input_pkg::PRM_COUNT;

    logic [PN-1:0][7:0] prm_r;
    logic [PN-1:0][7:0] prm_nxt;
    logic               rdValid_nxt;
    logic [7:0]         rdData_nxt;
    logic               slotHit;
    logic [2:0]         slot;
    logic               stopOnly;
    logic [7:0]         wrByte;

    // ----------------------------------------
    // Address decode for all three access paths
    // ----------------------------------------
    always_comb begin
        slotHit = 1'b0;
        slot    = 3'h0;
        unique case (prmReq.mode)
            thermocouple_input_pkg::BY_RECORD: begin
                unique case (prmReq.record_set_number)
                    thermocouple_input_pkg::REC_DIAG: begin
                        slotHit = 1'b1;
                        slot    = prmReq.byteSel ? thermocouple_input_pkg::SLOT_OPEN
                                                 : thermocouple_input_pkg::SLOT_DIAG;
                    end
                    thermocouple_input_pkg::REC_UNIT: begin
                        slotHit = 1'b1;
                        slot    = prmReq.byteSel ? thermocouple_input_pkg::SLOT_MAINS
                                                 : thermocouple_input_pkg::SLOT_UNIT;
                    end
                    thermocouple_input_pkg::REC_CH0: begin
                        slotHit = !prmReq.byteSel;
                        slot    = thermocouple_input_pkg::SLOT_CH0;
                    end
                    thermocouple_input_pkg::REC_CH1: begin
                        slotHit = !prmReq.byteSel;
                        slot    = thermocouple_input_pkg::SLOT_CH1;
                    end
                    default: slotHit = 1'b0;
                endcase
            end
            thermocouple_input_pkg::BY_INDEX: begin
                slot    = 3'(prmReq.object_index - thermocouple_input_pkg::INDEX_BASE);
                slotHit = prmReq.object_index >= thermocouple_input_pkg::INDEX_BASE
                       && prmReq.object_index < thermocouple_input_pkg::INDEX_BASE + 16'(PN);
            end
            thermocouple_input_pkg::BY_SUBINDEX: begin
                slot    = 3'(prmReq.object_subindex - thermocouple_input_pkg::SUBINDEX_LOW);
                slotHit = prmReq.object_subindex >= thermocouple_input_pkg::SUBINDEX_LOW
                       && prmReq.object_subindex < thermocouple_input_pkg::SUBINDEX_LOW + 8'(PN);
            end
            default: slotHit = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Parameter byte writes
    // ----------------------------------------
    // Stop-only bytes are refused while running, so a misbehaving
    // controller cannot change them mid-operation
    always_comb begin
        prm_nxt    = prm_r;
        stopOnly   = slot == thermocouple_input_pkg::SLOT_DIAG
                  || slot == thermocouple_input_pkg::SLOT_OPEN;
        prmRefused = prmWrite && (!slotHit || (stopOnly && systemRunning));
        prmAccept  = prmWrite && !prmRefused;
        unique case (slot)
            thermocouple_input_pkg::SLOT_OPEN,
            thermocouple_input_pkg::SLOT_UNIT,
            thermocouple_input_pkg::SLOT_MAINS:
                wrByte = prmReq.data & thermocouple_input_pkg::LOW2_MASK;
            default: wrByte = prmReq.data;
        endcase
        if (prmAccept)
            prm_nxt[slot] = wrByte;
    end

    // ----------------------------------------
    // Parameter readback
    // ----------------------------------------
    always_comb begin
        rdValid_nxt = prmRead && slotHit;
        rdData_nxt  = prmRdData_r;
        if (rdValid_nxt)
            rdData_nxt = prm_r[slot];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prm_r        <= thermocouple_input_pkg::PRM_RESET;
            prmRdValid_r <= 1'b0;
            prmRdData_r  <= 8'h00;
        end else begin
            prm_r        <= prm_nxt;
            prmRdValid_r <= rdValid_nxt;
            prmRdData_r  <= rdData_nxt;
        end
    end

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    assign diagIrqEnable = prm_r[thermocouple_input_pkg::SLOT_DIAG]
                        == thermocouple_input_pkg::DIAG_ON;
    assign openCircuitEnable = prm_r[thermocouple_input_pkg::SLOT_OPEN][NUM_CH-1:0]
                             & channelActive;
    assign unitSel = prm_r[thermocouple_input_pkg::SLOT_UNIT][1:0];
    // Reserved mains codes fall back to 50 Hz, the reset choice
    assign mainsRejection =
        (prm_r[thermocouple_input_pkg::SLOT_MAINS][1:0] == thermocouple_input_pkg::MAINS_60)
        ? thermocouple_input_pkg::MAINS_60 : thermocouple_input_pkg::MAINS_50;

    // ----------------------------------------
    // Per-channel result words
    // ----------------------------------------
    logic [NUM_CH-1:0][15:0] word;
    logic [NUM_CH-1:0][15:0] result_r;
    logic [NUM_CH-1:0][15:0] result_nxt;
    logic [NUM_CH-1:0]       update_nxt;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        assign channelActive[ch] = prm_r[thermocouple_input_pkg::SLOT_CH0 + 3'(ch)]
                                != thermocouple_input_pkg::RANGE_OFF;

        range_scaler #(
            .RAW_W     (RAW_W)
        ) u_scaler (
            .rangeCode (prm_r[thermocouple_input_pkg::SLOT_CH0 + 3'(ch)]),
            .unitSel   (unitSel),
            .raw       (sample[ch].raw[RAW_W-1:0]),
            .temp      (sample[ch].temp),
            .word      (word[ch])
        );

        // Deactivated channels ignore conversions and keep their last word
        always_comb begin
            update_nxt[ch] = sampleValid[ch] && channelActive[ch];
            result_nxt[ch] = result_r[ch];
            if (update_nxt[ch])
                result_nxt[ch] = word[ch];
        end

        assign inputData_r[ch*16 +: 16] = result_r[ch];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            result_r       <= '0;
            resultUpdate_r <= '0;
        end else begin
            result_r       <= result_nxt;
            resultUpdate_r <= update_nxt;
        end
    end

endmodule : thermocouple_input_config

// ==== verilog/thermocouple_input_pkg.sv ====
// Constants, types and register layout of the thermocouple input block
package thermocouple_input_pkg;

    // ----------------------------------------
    // Parameter byte slots (one byte each)
    // ----------------------------------------
    localparam int PRM_COUNT = 6;
    localparam logic [2:0] SLOT_DIAG  = 3'h0;
    localparam logic [2:0] SLOT_OPEN  = 3'h1;
    localparam logic [2:0] SLOT_UNIT  = 3'h2;
    localparam logic [2:0] SLOT_MAINS = 3'h3;
    localparam logic [2:0] SLOT_CH0   = 3'h4;
    localparam logic [2:0] SLOT_CH1   = 3'h5;

    // ----------------------------------------
    // Addressing: record set, object index, object subindex
    // ----------------------------------------
    localparam logic [7:0]  REC_DIAG     = 8'h00;
    localparam logic [7:0]  REC_UNIT     = 8'h01;
    localparam logic [7:0]  REC_CH0      = 8'h80;
    localparam logic [7:0]  REC_CH1      = 8'h81;
    localparam logic [15:0] INDEX_BASE   = 16'h3100;
    localparam logic [7:0]  SUBINDEX_LOW = 8'h01;

    // ----------------------------------------
    // Reset values and field codes
    // ----------------------------------------
    localparam logic [7:0] DIAG_RESET  = 8'h00;
    localparam logic [7:0] OPEN_RESET  = 8'h00;
    localparam logic [7:0] UNIT_RESET  = 8'h00;
    localparam logic [7:0] MAINS_RESET = 8'h02;
    localparam logic [7:0] RANGE_RESET = 8'hC1;
    localparam logic [PRM_COUNT-1:0][7:0] PRM_RESET =
        {RANGE_RESET, RANGE_RESET, MAINS_RESET, UNIT_RESET, OPEN_RESET, DIAG_RESET};
    localparam logic [7:0] DIAG_ON       = 8'h40;
    localparam logic [7:0] LOW2_MASK     = 8'h03;
    localparam logic [1:0] UNIT_CELSIUS  = 2'h0;
    localparam logic [1:0] UNIT_FAHR     = 2'h1;
    localparam logic [1:0] UNIT_KELVIN   = 2'h2;
    localparam logic [1:0] MAINS_60      = 2'h1;
    localparam logic [1:0] MAINS_50      = 2'h2;
    localparam logic [7:0] RANGE_OFF     = 8'hFF;
    localparam logic [7:0] RANGE_MV_WIDE = 8'h11;
    localparam logic [7:0] RANGE_MV_STD  = 8'h21;
    localparam logic [3:0] TC_EXT_COMP   = 4'hB;
    localparam logic [3:0] TC_INT_COMP   = 4'hC;
    localparam logic [3:0] TC_TYPE_LAST  = 4'h9;

    // ----------------------------------------
    // Result scaling
    // ----------------------------------------
    localparam logic [15:0] WIDE_NOMINAL   = 16'h6C00;
    localparam logic [15:0] WIDE_OVER_MAX  = 16'h7EFF;
    localparam logic [15:0] WIDE_UNDER_MIN = 16'h8100;
    localparam int          STD_NOM_BITS   = 14;
    localparam logic [15:0] STD_OVER_MAX   = 16'h5000;
    localparam logic [15:0] STD_UNDER_MIN  = 16'hB000;
    localparam logic [15:0] WORD_OVERFLOW  = 16'h7FFF;
    localparam logic [15:0] WORD_UNDERFLOW = 16'h8000;
    localparam logic [15:0] FAHR_OFFSET    = 16'h0140;
    localparam logic [15:0] KELVIN_OFFSET  = 16'h0AAC;
    localparam logic [3:0]  FAHR_MUL       = 4'h9;
    localparam logic [3:0]  FAHR_DIV       = 4'h5;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {BY_RECORD, BY_INDEX, BY_SUBINDEX} addr_mode_e;

    typedef struct packed {
        addr_mode_e  mode;
        logic [7:0]  record_set_number;
        logic        byteSel;
        logic [15:0] object_index;
        logic [7:0]  object_subindex;
        logic [7:0]  data;
    } param_req_s;

    typedef struct packed {
        logic [23:0] raw;
        logic [15:0] temp;
    } sample_s;

endpackage : thermocouple_input_pkg

// ==== verilog/range_scaler.sv ====
// Converts one channel sample into its signed 16-bit result word
`timescale 1ns/1ps
module range_scaler #(
    parameter int RAW_W = 24
) (
    input  wire logic [7:0]       rangeCode,
    input  wire logic [1:0]       unitSel,
    input  wire logic [RAW_W-1:0] raw,
    input  wire logic [15:0]      temp,
    output logic      [15:0]      word
);
    localparam int PW = RAW_W + 17;
    typedef logic signed [PW-1:0] wide_t;
    typedef logic signed [19:0]   temp_t;

    wide_t prod;
    wide_t wideVal;
    wide_t stdVal;
    temp_t tIn;
    temp_t tOut;
    logic  isTc;

    // ----------------------------------------
    // Millivolt scaling: raw full scale 80 mV at 2^(RAW_W-2)
    // ----------------------------------------
    always_comb begin
        prod    = wide_t'($signed(raw)) * wide_t'($signed({1'b0, thermocouple_input_pkg::WIDE_NOMINAL}));
        wideVal = prod >>> (RAW_W - 2);
        stdVal  = wide_t'($signed(raw)) >>> (RAW_W - 2 - thermocouple_input_pkg::STD_NOM_BITS);
    end

    // ----------------------------------------
    // Temperature unit conversion, tenths of a degree
    // ----------------------------------------
    always_comb begin
        tIn = temp_t'($signed(temp));
        unique case (unitSel)
            thermocouple_input_pkg::UNIT_FAHR:   tOut = temp_t'(tIn
                * temp_t'(thermocouple_input_pkg::FAHR_MUL)
                / temp_t'(thermocouple_input_pkg::FAHR_DIV))
                + temp_t'(thermocouple_input_pkg::FAHR_OFFSET);
            thermocouple_input_pkg::UNIT_KELVIN: tOut = tIn
                + temp_t'(thermocouple_input_pkg::KELVIN_OFFSET);
            default:                             tOut = tIn;
        endcase
    end

    // ----------------------------------------
    // Word selection and band limits
    // ----------------------------------------
    always_comb begin
        isTc = (rangeCode[7:4] == thermocouple_input_pkg::TC_EXT_COMP
             || rangeCode[7:4] == thermocouple_input_pkg::TC_INT_COMP)
             && rangeCode[3:0] <= thermocouple_input_pkg::TC_TYPE_LAST;
        word = thermocouple_input_pkg::WORD_OVERFLOW;
        if (rangeCode == thermocouple_input_pkg::RANGE_MV_WIDE) begin
            if (wideVal > wide_t'(signed'(thermocouple_input_pkg::WIDE_OVER_MAX)))
                word = thermocouple_input_pkg::WORD_OVERFLOW;
            else if (wideVal < wide_t'(signed'(thermocouple_input_pkg::WIDE_UNDER_MIN)))
                word = thermocouple_input_pkg::WORD_UNDERFLOW;
            else
                word = wideVal[15:0];
        end else if (rangeCode == thermocouple_input_pkg::RANGE_MV_STD) begin
            if (stdVal > wide_t'(signed'(thermocouple_input_pkg::STD_OVER_MAX)))
                word = thermocouple_input_pkg::WORD_OVERFLOW;
            else if (stdVal < wide_t'(signed'(thermocouple_input_pkg::STD_UNDER_MIN)))
                word = thermocouple_input_pkg::WORD_UNDERFLOW;
            else
                word = stdVal[15:0];
        end else if (isTc) begin
            if (tOut > temp_t'(signed'(thermocouple_input_pkg::WORD_OVERFLOW)))
                word = thermocouple_input_pkg::WORD_OVERFLOW;
            else if (tOut < temp_t'(signed'(thermocouple_input_pkg::WORD_UNDERFLOW)))
                word = thermocouple_input_pkg::WORD_UNDERFLOW;
            else
                word = tOut[15:0];
        end
    end

endmodule : range_scaler

// ==== dv/thermocouple_input_config_assertions.sv ====
// Port checks for the thermocouple input block
`timescale 1ns/1ps
module thermocouple_input_config_assertions #(
    parameter int NUM_CH = 2,
    parameter int RAW_W  = 24
) (
    input wire logic                               ref_clk,
    input wire logic                               resetn,
    input wire logic                               prmWrite,
    input wire logic                               prmRead,
    input wire thermocouple_input_pkg::param_req_s prmReq,
    input wire logic                               systemRunning,
    input wire logic                               prmAccept,
    input wire logic                               prmRefused,
    input wire logic                               prmRdValid_r,
    input wire logic [NUM_CH-1:0]                  sampleValid,
    input wire logic [NUM_CH*16-1:0]               inputData_r,
    input wire logic [NUM_CH-1:0]                  resultUpdate_r,
    input wire logic [NUM_CH-1:0]                  channelActive,
    input wire logic [NUM_CH-1:0]                  openCircuitEnable,
    input wire logic                               diagIrqEnable,
    input wire logic [1:0]                         mainsRejection,
    input wire logic [1:0]                         unitSel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Record-mode writes: stop-only record, diag byte, unit byte; samples to take
    wire recWr = prmWrite && prmReq.mode == thermocouple_input_pkg::BY_RECORD;
    wire stopWr = recWr && prmReq.record_set_number == 8'h00;
    wire diagWr = stopWr && !prmReq.byteSel;
    wire unitWr = recWr && prmReq.record_set_number == 8'h01 && !prmReq.byteSel;
    wire [NUM_CH-1:0] takeMask = sampleValid & channelActive;

    a_diag_enable_value: assert property (
        diagWr && prmAccept |=> diagIrqEnable == ($past(prmReq.data) == 8'h40))
        else $error("diag enable wrong");
    a_stop_only_refused: assert property (
        stopWr && systemRunning |-> prmRefused && !prmAccept)
        else $error("stop-only byte taken while running");
    a_open_gated: assert property (
        (openCircuitEnable & ~channelActive) == '0)
        else $error("open-circuit enable on inactive channel");
    a_unit_follow: assert property (
        unitWr && prmAccept |=> unitSel == $past(prmReq.data[1:0]))
        else $error("unit select wrong");
    a_mains_legal: assert property (
        mainsRejection inside {2'h1, 2'h2})
        else $error("mains rejection output illegal");
    a_reset_defaults: assert property (
        $rose(resetn) |-> channelActive == '1 && mainsRejection == 2'h2 && unitSel == 2'h0
        && !diagIrqEnable) else $error("reset values wrong");
    a_read_answer: assert property (
        prmRdValid_r |-> $past(prmRead)) else $error("read valid without read");
    a_update_pulse: assert property (
        ##1 resultUpdate_r == $past(takeMask)) else $error("update pulse mismatch");
    a_word_hold: assert property (
        resultUpdate_r == '0 |-> $stable(inputData_r)) else $error("word changed without update");

    // Main scenarios
    c_refuse: cover property (stopWr && systemRunning);
    c_inactive: cover property (sampleValid != '0 && channelActive != '1);
    c_read: cover property (prmRdValid_r);
endmodule : thermocouple_input_config_assertions

// ==== dv/bus_coupler_model.sv ====
// Bus coupler model relaying controller parameter bytes to the block
`timescale 1ns/1ps
module bus_coupler_model (
    input  wire logic                          ref_clk,
    input  wire logic                          prmAccept,
    input  wire logic [7:0]                    prmRdData_r,
    input  wire logic                          prmRdValid_r,
    output logic                               prmWrite,
    output logic                               prmRead,
    output thermocouple_input_pkg::param_req_s prmReq,
    output logic                               systemRunning
);
    // Idle bus at time zero
    initial begin
        prmWrite = 1'b0;
        prmRead = 1'b0;
        prmReq = '0;
        systemRunning = 1'b0;
    end

    // Slot number to record, index and subindex; slot 6 is unmapped
    function automatic thermocouple_input_pkg::param_req_s addr(input logic [2:0] s,
                                                              input logic [1:0] m);
        thermocouple_input_pkg::param_req_s r;
        r = '0;
        r.mode = thermocouple_input_pkg::addr_mode_e'(m);
        r.record_set_number = (s[2] && s != 3'h6) ? {7'h40, s[0]} : {6'h00, s[2:1]};
        r.byteSel = s[0] & ~s[2];
        r.object_index = 16'h3100 + 16'(s);
        r.object_subindex = 8'h01 + 8'(s);
        return r;
    endfunction : addr

    // One byte write; stop-only bytes go out while stopped unless viol
    task automatic wr(input logic [2:0] s, input logic [1:0] m, input logic [7:0] d,
                      input logic run, viol, output logic acc);
        @(posedge ref_clk);
        #1;
        systemRunning = run && !(s < 3'h2 && !viol);
        prmReq = addr(s, m);
        prmReq.data = d;
        prmWrite = 1'b1;
        @(posedge ref_clk);
        acc = prmAccept;
        #1;
        prmWrite = 1'b0;
        prmReq = ~prmReq;
    endtask : wr

    // One byte read; answer taken one cycle after the strobe
    task automatic rd(input logic [2:0] s, input logic [1:0] m,
                      output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        #1;
        prmReq = addr(s, m);
        prmRead = 1'b1;
        @(posedge ref_clk);
        #1;
        prmRead = 1'b0;
        prmReq = ~prmReq;
        v = prmRdValid_r;
        d = prmRdData_r;
    endtask : rd
endmodule : bus_coupler_model

// ==== dv/thermocouple_input_config_tb_top.sv ====
// Self-checking bench of the thermocouple input block
`timescale 1ns/1ps
module thermocouple_input_config_tb_top;
    logic                                  ref_clk, resetn, prmWrite, prmRead, systemRunning;
    logic                                  prmAccept, prmRefused, prmRdValid_r, diagIrqEnable;
    logic [7:0]                            prmRdData_r, d, sh [6];
    logic [1:0]                            sampleValid, resultUpdate_r, channelActive;
    logic [1:0]                            openCircuitEnable, mainsRejection, unitSel;
    logic [31:0]                           inputData_r;
    logic [15:0]                           last [2];
    logic                                  acc, v;
    thermocouple_input_pkg::param_req_s    prmReq;
    thermocouple_input_pkg::sample_s [1:0] sample;
    int                                    comparisons, miscompares, cycles;
    localparam logic [23:0] RAWS [8] = '{24'h40_0000, 24'hC0_0000, 24'h00_0000, 24'h50_0000,
                                         24'h50_0100, 24'hB0_0000, 24'h7F_FFFF, 24'h80_0000};

    thermocouple_input_config DUT (.ref_clk, .resetn, .prmWrite, .prmRead, .prmReq,
        .systemRunning, .prmAccept, .prmRefused, .prmRdData_r, .prmRdValid_r, .sampleValid,
        .sample, .inputData_r, .resultUpdate_r, .channelActive, .openCircuitEnable,
        .diagIrqEnable, .mainsRejection, .unitSel);
    bus_coupler_model cpl (.ref_clk, .prmAccept, .prmRdData_r, .prmRdValid_r, .prmWrite,
        .prmRead, .prmReq, .systemRunning);

    // Clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    task automatic chk(input string n, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Expected result word of a channel
    function automatic logic [15:0] expWord(input logic [7:0] c, input logic [23:0] raw,
                                            input logic [15:0] t, input logic [1:0] u);
        longint x;
        x = 32767;
        if (c == 8'h11) x = (longint'(signed'(raw)) * 27648) >>> 22;
        if (c == 8'h21) x = longint'(signed'(raw)) >>> 8;
        if (c[7:4] inside {4'hB, 4'hC} && c[3:0] <= 4'h9) begin
            x = longint'(signed'(t));
            x = (u == 2'h1) ? x * 9 / 5 + 320 : (u == 2'h2) ? x + 2732 : x;
        end
        if (c == 8'h11) x = x > 32511 ? 32767 : (x < -32512 ? -32768 : x);
        if (c == 8'h21) x = x > 20480 ? 32767 : (x < -20480 ? -32768 : x);
        x = x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
        return x[15:0];
    endfunction : expWord

    task automatic chkOut();
        logic [1:0] act;
        act = {sh[5] != 8'hFF, sh[4] != 8'hFF};
        chk("channelActive", channelActive, act);
        chk("diagIrqEnable", diagIrqEnable, sh[0] == 8'h40);
        chk("openCircuitEnable", openCircuitEnable, sh[1][1:0] & act);
        chk("unitSel", unitSel, sh[2][1:0]);
        chk("mainsRejection", mainsRejection, (sh[3][1:0] == 2'h1) ? 2'h1 : 2'h2);
    endtask : chkOut

    // Both channels sampled in the same cycle
    task automatic smp(input logic [23:0] r, input logic [15:0] t);
        logic [1:0] act;
        act = {sh[5] != 8'hFF, sh[4] != 8'hFF};
        @(posedge ref_clk);
        #1;
        sample = {r, t, r, t};
        sampleValid = 2'b11;
        @(posedge ref_clk);
        #1;
        sampleValid = 2'b00;
        sample = ~sample;
        for (int c = 0; c < 2; c++) if (act[c]) last[c] = expWord(sh[4+c], r, t, sh[2][1:0]);
        chk("inputData_r", inputData_r, {last[1], last[0]});
        chk("resultUpdate_r", resultUpdate_r, act);
    endtask : smp

    task automatic put(input logic [2:0] s, input logic [7:0] x);
        cpl.wr(s, 2'(s % 3), x, 1'b0, 1'b0, acc);
        sh[s] = (s inside {3'h1, 3'h2, 3'h3}) ? (x & 8'h03) : x;
    endtask : put

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        resetn = 1'b0;
        sampleValid = 2'b00;
        sample = '0;
        last = '{16'h0000, 16'h0000};
        sh = '{8'h00, 8'h00, 8'h00, 8'h02, 8'hC1, 8'hC1};
        void'($urandom(70684));
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        chkOut();
        for (int s = 0; s < 6; s++) begin
            cpl.rd(3'(s), 2'h2, d, v);
            chk("default byte", {v, d}, {1'b1, sh[s]});
        end
        $display("defaults done");
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 8'h40 : (i == 6) ? 8'h41 : 8'($urandom);
            cpl.wr(3'(i % 6), 2'(i / 6 % 3), d, 1'($urandom), 1'b0, acc);
            chk("accept", acc, 1'b1);
            sh[i % 6] = (i % 6 inside {1, 2, 3}) ? (d & 8'h03) : d;
            chkOut();
            cpl.rd(3'(i % 6), 2'((i + 1) % 3), d, v);
            chk("readback", {v, d}, {1'b1, sh[i % 6]});
        end
        $display("config done");
        for (int s = 0; s < 2; s++) begin
            cpl.wr(3'(s), 2'(s), 8'h03, 1'b1, 1'b1, acc);
            chk("refused", acc, 1'b0);
        end
        cpl.wr(3'h6, 2'h1, 8'h00, 1'b0, 1'b0, acc);
        chk("unmapped", acc, 1'b0);
        cpl.rd(3'h6, 2'h2, d, v);
        chk("unmapped read", v, 1'b0);
        chkOut();
        $display("refusal done");
        put(3'h4, 8'h11);
        put(3'h5, 8'h21);
        for (int i = 0; i < 30; i++) smp(i < 8 ? RAWS[i] : 24'($urandom), 16'($urandom));
        for (int i = 0; i < 12; i++) begin
            put(3'h2, 8'($urandom));
            put(3'h4, {($urandom_range(1) ? 4'hB : 4'hC), 4'($urandom_range(9))});
            smp(24'($urandom), 16'($urandom_range(8000)) - 16'h0FA0);
        end
        put(3'h4, 8'h50);
        put(3'h5, 8'hFF);
        chkOut();
        smp(24'($urandom), 16'h0100);
        $display("samples done");
        results();
    end
endmodule : thermocouple_input_config_tb_top

bind thermocouple_input_config thermocouple_input_config_assertions #(
    .NUM_CH(NUM_CH), .RAW_W(RAW_W)) chk_i (.ref_clk, .resetn, .prmWrite, .prmRead, .prmReq,
    .systemRunning, .prmAccept, .prmRefused, .prmRdValid_r, .sampleValid, .inputData_r,
    .resultUpdate_r, .channelActive, .openCircuitEnable, .diagIrqEnable, .mainsRejection,
    .unitSel);
